/* bench/regenerator_startup_sequencer_tb_top.sv */
`default_nettype none
module regenerator_startup_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] OWN_C   = 16'hF0F3;
  localparam logic [7:0]  OWN_CUR = 8'h06;
  localparam logic [7:0]  OWN_WC  = 8'h03;
  localparam int          HOLD    = 50;

  logic              core_clk;
  logic              sys_rst;
  logic              regen_start;
  rss_pkg::rss_msg_t ln_rx;
  rss_pkg::rss_msg_t ln_tx;
  rss_pkg::rss_msg_t cu_rx;
  rss_pkg::rss_msg_t cu_tx;
  logic              span_up;
  logic              startup_fail;
  logic              deact_all;
  int                bad_count;
  int                n_checks;
  int                fail_seen;
  rss_pkg::rss_msg_t got;
  logic              ok;

  always #50 core_clk = ~core_clk;

  rss_regen_seq #(.OWN_CAPS(OWN_C), .OWN_TM_CUR(OWN_CUR),
                  .OWN_TM_WC(OWN_WC), .HOLD_CYCLES(32'(HOLD))) DUT (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .LN_RX(ln_rx), .LN_TX(ln_tx),
    .CU_RX(cu_rx), .CU_TX(cu_tx), .REGEN_START(regen_start),
    .SPAN_UP(span_up), .STARTUP_FAIL(startup_fail), .DEACT_ALL(deact_all));
  rss_nbr_model ln_unit (.clk(core_clk), .rx(ln_tx), .tx(ln_rx));
  rss_nbr_model nw_unit (.clk(core_clk), .rx(cu_tx), .tx(cu_rx));

  always @(posedge core_clk) begin
    if (startup_fail === 1'b1) fail_seen++;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Checks: %0d, errors: %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic c, input string what);
    n_checks++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    regen_start <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
    chk(span_up === 1'b0 && startup_fail === 1'b0 && deact_all === 1'b0
        && ln_tx.vld === 1'b0 && cu_tx.vld === 1'b0, "outputs not idle");
    @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  // Side 1 is the network-ward segment, side 0 the line segment
  task automatic see(input logic cu, input rss_pkg::rss_kind_t k,
                     input int lim, input string what);
    if (cu) nw_unit.wait_rx(k, lim, got, ok);
    else ln_unit.wait_rx(k, lim, got, ok);
    chk(ok, what);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_line_start();
    do_reset(2);
    ln_unit.send(rss_pkg::RSS_K_START, 1'b0);
    ln_unit.send(rss_pkg::RSS_K_CAPS, 1'b1, 16'h0F0F);
    see(0, rss_pkg::RSS_K_MS, 3, "line unit not held off");
    chk(got.rsp === 1'b1, "hold-off lacks pending bit");
    see(1, rss_pkg::RSS_K_START, 4, "no onward session");
    see(1, rss_pkg::RSS_K_CAPS, 2, "no onward caps");
    chk(got.co_tm === 1'b1, "margins not marked");
    chk(got.tm_cur === 8'h21 && got.tm_wc === 8'h12, "margins lost");
    chk(got.caps === (OWN_C & 16'h0F0F), "onward caps wrong");
    ln_unit.send(rss_pkg::RSS_K_START);
    see(0, rss_pkg::RSS_K_MS, 4, "reopen not answered");
    chk(got.rsp === 1'b1, "reopen not held off");
    nw_unit.send(rss_pkg::RSS_K_MS, 1'b1, 16'h0000, 1'b1);
    nw_unit.send(rss_pkg::RSS_K_START, 1'b0);
    nw_unit.send(rss_pkg::RSS_K_CAPS, 1'b1, 16'h00FF);
    see(1, rss_pkg::RSS_K_MS, 4, "network unit not held off");
    chk(got.rsp === 1'b1, "network hold-off lacks bit");
    see(0, rss_pkg::RSS_K_START, 4, "no session to line");
    see(0, rss_pkg::RSS_K_CAPS, 2, "no caps to line");
    chk(got.caps === (OWN_C & 16'h00FF), "line caps wrong");
    ln_unit.send(rss_pkg::RSS_K_MS);
    ln_unit.send(rss_pkg::RSS_K_ACT);
    see(1, rss_pkg::RSS_K_START, 4, "activation not passed");
    see(1, rss_pkg::RSS_K_MS, 2, "no mode select onward");
    chk(got.rsp === 1'b0 && span_up === 1'b0, "early span up");
    nw_unit.send(rss_pkg::RSS_K_ACT);
    for (int i = 0; i < 3 && span_up !== 1'b1; i++) @(posedge core_clk);
    #1;
    chk(span_up === 1'b1, "span not up");
    nw_unit.send(rss_pkg::RSS_K_DEACT);
    see(0, rss_pkg::RSS_K_DEACT, 3, "line not deactivated");
    chk(cu_tx.vld === 1'b1 && cu_tx.kind === rss_pkg::RSS_K_DEACT
        && deact_all === 1'b1, "span not torn down");
    @(posedge core_clk);
    #1;
    chk(span_up === 1'b0, "span still up");
  endtask

  task automatic t_regen_timer();
    int f0;
    int n;
    do_reset(2);
    regen_start <= 1'b1;
    see(1, rss_pkg::RSS_K_START, 4, "no downstream train");
    regen_start <= 1'b0;
    see(1, rss_pkg::RSS_K_CAPS, 2, "no downstream caps");
    chk(got.co_tm === 1'b0 && got.tm_cur === OWN_CUR
        && got.tm_wc === OWN_WC, "own margins wrong");
    f0 = fail_seen;
    n = 0;
    nw_unit.send(rss_pkg::RSS_K_MS, 1'b1, 16'h0000, 1'b1);
    while (fail_seen == f0 && n < HOLD + 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n >= HOLD && n <= HOLD + 6, "expiry out of range");
    @(posedge core_clk);
    regen_start <= 1'b1;
    see(1, rss_pkg::RSS_K_START, 4, "not idle after fail");
    regen_start <= 1'b0;
  endtask

  task automatic t_collision();
    do_reset(2);
    fork
      ln_unit.send(rss_pkg::RSS_K_START);
      nw_unit.send(rss_pkg::RSS_K_START);
    join
    see(0, rss_pkg::RSS_K_MS, 4, "line start not held");
    chk(got.rsp === 1'b1, "line start won collision");
  endtask

  task automatic t_diag();
    int f0;
    do_reset(2);
    ln_unit.send(rss_pkg::RSS_K_START, 1'b0, 16'h0000, 1'b0, 1'b1);
    ln_unit.send(rss_pkg::RSS_K_CAPS, 1'b1, 16'h0F0F, 1'b0, 1'b1);
    see(0, rss_pkg::RSS_K_MS, 3, "diag start not held");
    see(1, rss_pkg::RSS_K_CAPS, 6, "diag caps not sent");
    f0 = fail_seen;
    nw_unit.send(rss_pkg::RSS_K_MS, 1'b1, 16'h0000, 1'b1);
    see(0, rss_pkg::RSS_K_START, HOLD + 20, "diag not finished");
    see(0, rss_pkg::RSS_K_CAPS, 2, "diag caps missing");
    chk(got.caps === OWN_C, "diag caps wrong");
    chk(fail_seen == f0, "failure in diag mode");
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    regen_start = 1'b0;
    bad_count = 0;
    n_checks = 0;
    fail_seen = 0;
    do_reset(5);
    t_line_start();
    t_regen_timer();
    t_collision();
    t_diag();
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    $display("Error at %0t ns: watchdog expired", $time);
    report_and_stop();
  end
endmodule // regenerator_startup_sequencer_tb_top
`default_nettype wire

/* bench/rss_nbr_model.sv */
`default_nettype none
module rss_nbr_model (
  // Clock
  input  wire logic              clk,
  // Segment toward the sequencer
  input  wire rss_pkg::rss_msg_t rx,
  output var  rss_pkg::rss_msg_t tx
);
  timeunit 1ns;
  timeprecision 100ps;

  initial tx = rss_pkg::MSG_RST;

  // ------------------------------------------------------------------
  // Sending
  // ------------------------------------------------------------------
  // Between messages the word is scrambled, so only vld can be trusted
  task automatic send(input rss_pkg::rss_kind_t k, input logic last = 1'b1,
                      input logic [15:0] caps = 16'h0000,
                      input logic rsp = 1'b0, input logic diag = 1'b0);
    rss_pkg::rss_msg_t m;
    rss_pkg::rss_msg_t r;
    m = '{vld: 1'b1, kind: k, rsp: rsp, co_tm: 1'b0, diag: diag,
          tm_cur: 8'h21, tm_wc: 8'h12, caps: caps};
    r = ~m;
    r.vld = 1'b0;
    @(posedge clk);
    tx <= m;
    if (last) begin
      @(posedge clk);
      tx <= r;
    end
  endtask

  // ------------------------------------------------------------------
  // Receiving
  // ------------------------------------------------------------------
  task automatic wait_rx(input rss_pkg::rss_kind_t k, input int lim,
                         output rss_pkg::rss_msg_t got, output logic ok);
    int n;
    ok = 1'b0;
    got = rss_pkg::MSG_RST;
    n = 0;
    #1;
    while (!ok && n <= lim) begin
      if (rx.vld === 1'b1 && rx.kind === k) begin
        ok = 1'b1;
        got = rx;
      end else begin
        @(posedge clk);
        #1;
        n++;
      end
    end
  endtask
endmodule // rss_nbr_model
`default_nettype wire

/* rtl/rss_holdoff_timer.sv */
`default_nettype none
module rss_holdoff_timer #(
  parameter int                   W     = rss_pkg::TMR_W,
  parameter logic [W-1:0]         COUNT = W'(rss_pkg::HOLD_CYC)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic stop,
  // Status
  output var  logic running,
  output var  logic expired
);

  logic [W-1:0] cnt_q;

  // ------------------------------------------------------------------
  // Count down; a restart reloads so a repeat hold-off gets full time
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || stop) begin
      cnt_q   <= '0;
      running <= 1'b0;
    end else if (start) begin
      cnt_q   <= COUNT;
      running <= 1'b1;
    end else if (running && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end else if (running) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || stop || start) begin
      expired <= 1'b0;
    end else begin
      expired <= running && cnt_q == '0;
    end
  end

  // Expiry does not come in the two cycles after a start
  expire_late_a: assert property (@(posedge clk) disable iff (rst)
    start && !stop |=> !expired [*2])
    else $error("hold-off timer expired too early");

endmodule : rss_holdoff_timer
`default_nettype wire

/* rtl/rss_pkg.sv */
`default_nettype none
package rss_pkg;

  // ------------------------------------------------------------------
  // Session message carried on either segment
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RSS_K_START,
    RSS_K_CAPS,
    RSS_K_PROBE,
    RSS_K_MS,
    RSS_K_ACT,
    RSS_K_DEACT
  } rss_kind_t;

  typedef struct packed {
    logic        vld;
    rss_kind_t   kind;
    logic        rsp;      // Response-pending bit of a mode-select
    logic        co_tm;    // Margins come from the central office side
    logic        diag;     // Diagnostic-mode bit
    logic [7:0]  tm_cur;   // Current-condition target margin
    logic [7:0]  tm_wc;    // Worst-case target margin
    logic [15:0] caps;
  } rss_msg_t;

  localparam int CAPS_W = 16;
  localparam int TM_W   = 8;

  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam rss_msg_t MSG_RST     = '0;
  localparam logic [7:0] TM_RST    = 8'h00;
  localparam logic [15:0] CAPS_RST = 16'h0000;

  localparam longint unsigned CLK_HZ    = 64'd10_000_000;
  localparam longint unsigned HOLD_MIN  = 64'd4;
  localparam longint unsigned HOLD_CYC  = HOLD_MIN * 64'd60 * CLK_HZ;
  localparam int              TMR_W     = 32;

endpackage : rss_pkg
`default_nettype wire

/* rtl/rss_regen_seq.sv */
`default_nettype none
module rss_regen_seq #(
  parameter logic [15:0] OWN_CAPS    = 16'hFFFF,
  parameter logic [7:0]  OWN_TM_CUR  = 8'h06,
  parameter logic [7:0]  OWN_TM_WC   = 8'h03,
  parameter logic [31:0] HOLD_CYCLES = 32'(rss_pkg::HOLD_CYC)
) (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              SYS_RST,
  // Line-facing segment
  input  wire rss_pkg::rss_msg_t LN_RX,
  output var  rss_pkg::rss_msg_t LN_TX,
  // Customer-facing segment
  input  wire rss_pkg::rss_msg_t CU_RX,
  output var  rss_pkg::rss_msg_t CU_TX,
  // Local control and status
  input  wire logic              REGEN_START,
  output var  logic              SPAN_UP,
  output var  logic              STARTUP_FAIL,
  output var  logic              DEACT_ALL
);

  typedef enum logic [3:0] {
    S_IDLE, S_LN_SESS, S_FWD_CU, S_FWD_CU2, S_CU_HOLD, S_WAIT,
    S_CU_SESS, S_FWD_LN, S_FWD_LN2, S_LN_HOLD, S_LN_ACT,
    S_ACT_CU, S_ACT_CU2, S_CU_ACT, S_UP
  } rss_state_t;

  rss_state_t        st_q, st_d;
  rss_pkg::rss_msg_t ln_d, cu_d;
  logic [7:0]        tm_cur_q, tm_wc_q;
  logic [15:0]       dn_caps_q, up_caps_q;
  logic              co_q, diag_q;
  logic              tmr_start, tmr_run, tmr_exp, retrain;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic is_k(rss_pkg::rss_msg_t m,
                                rss_pkg::rss_kind_t k);
    return m.vld && m.kind == k;
  endfunction

  function automatic rss_pkg::rss_msg_t mk(rss_pkg::rss_kind_t k,
                                           logic r);
    rss_pkg::rss_msg_t m;
    m      = rss_pkg::MSG_RST;
    m.vld  = 1'b1;
    m.kind = k;
    m.rsp  = r;
    return m;
  endfunction

  // Per-segment collisions are settled by the handshake itself; the
  // messages seen here are already arbitrated on each wire.
  assign retrain = is_k(LN_RX, rss_pkg::RSS_K_DEACT) ||
                   is_k(CU_RX, rss_pkg::RSS_K_DEACT);

  // Timer armed when a held mode-select arrives in S_CU_HOLD or S_LN_HOLD
  assign tmr_start = (st_q == S_CU_HOLD && is_k(CU_RX, rss_pkg::RSS_K_MS) &&
                      CU_RX.rsp) ||
                     (st_q == S_LN_HOLD && is_k(LN_RX, rss_pkg::RSS_K_MS) &&
                      LN_RX.rsp);

  rss_holdoff_timer #(
    .W     (rss_pkg::TMR_W),
    .COUNT (HOLD_CYCLES)
  ) u_tmr (
    .clk     (CORE_CLK),
    .rst     (SYS_RST),
    .start   (tmr_start),
    .stop    (retrain || st_q == S_LN_ACT),
    .running (tmr_run),
    .expired (tmr_exp)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    ln_d = rss_pkg::MSG_RST;
    cu_d = rss_pkg::MSG_RST;
    case (st_q)
      S_IDLE, S_WAIT: begin
        // Customer-side exchanges win a simultaneous start.
        if (is_k(CU_RX, rss_pkg::RSS_K_START)) begin
          st_d = S_CU_SESS;
        end else if (is_k(LN_RX, rss_pkg::RSS_K_START)) begin
          st_d = S_LN_SESS;
        end else if (st_q == S_IDLE && REGEN_START) begin
          st_d = S_FWD_CU;
        end else if (st_q == S_WAIT && tmr_exp) begin
          // Stuck span: in diagnostic mode finish the near segments.
          st_d = diag_q ? S_FWD_LN : S_IDLE;
        end
      end
      S_LN_SESS: begin
        if (is_k(LN_RX, rss_pkg::RSS_K_CAPS)) begin
          ln_d = mk(rss_pkg::RSS_K_MS, 1'b1);
          st_d = S_FWD_CU;
        end
      end
      S_FWD_CU: begin
        cu_d = mk(rss_pkg::RSS_K_START, 1'b0);
        st_d = S_FWD_CU2;
      end
      S_FWD_CU2: begin
        cu_d        = mk(rss_pkg::RSS_K_CAPS, 1'b0);
        cu_d.tm_cur = tm_cur_q;
        cu_d.tm_wc  = tm_wc_q;
        cu_d.co_tm  = co_q;
        cu_d.diag   = diag_q;
        cu_d.caps   = OWN_CAPS & up_caps_q;
        st_d        = S_CU_HOLD;
      end
      S_CU_HOLD: begin
        if (is_k(CU_RX, rss_pkg::RSS_K_MS)) begin
          st_d = CU_RX.rsp ? S_WAIT : S_IDLE;
        end else if (is_k(CU_RX, rss_pkg::RSS_K_CAPS)) begin
          // Network unit answered directly; it continues as its own start
          cu_d = mk(rss_pkg::RSS_K_MS, 1'b1);
          st_d = S_FWD_LN;
        end
      end
      S_CU_SESS: begin
        if (is_k(CU_RX, rss_pkg::RSS_K_CAPS)) begin
          cu_d = mk(rss_pkg::RSS_K_MS, 1'b1);
          st_d = S_FWD_LN;
        end
      end
      S_FWD_LN: begin
        ln_d = mk(rss_pkg::RSS_K_START, 1'b0);
        st_d = S_FWD_LN2;
      end
      S_FWD_LN2: begin
        ln_d        = mk(rss_pkg::RSS_K_CAPS, 1'b0);
        ln_d.tm_cur = tm_cur_q;
        ln_d.tm_wc  = tm_wc_q;
        ln_d.caps   = OWN_CAPS & dn_caps_q;
        st_d        = S_LN_HOLD;
      end
      S_LN_HOLD: begin
        if (is_k(LN_RX, rss_pkg::RSS_K_MS)) begin
          st_d = LN_RX.rsp ? S_WAIT : S_LN_ACT;
        end
      end
      S_LN_ACT: begin
        if (is_k(LN_RX, rss_pkg::RSS_K_ACT)) begin
          st_d = S_ACT_CU;
        end
      end
      S_ACT_CU: begin
        cu_d = mk(rss_pkg::RSS_K_START, 1'b0);
        st_d = S_ACT_CU2;
      end
      S_ACT_CU2: begin
        cu_d = mk(rss_pkg::RSS_K_MS, 1'b0);
        st_d = S_CU_ACT;
      end
      S_CU_ACT: begin
        if (is_k(CU_RX, rss_pkg::RSS_K_ACT) || diag_q) begin
          st_d = S_UP;
        end
      end
      S_UP: begin
        st_d = S_UP;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // Early reopen from a unit we are not serving is held off again
    // A line start that loses a collision is held off as well
    if (!ln_d.vld && st_q != S_LN_SESS &&
        ((st_q != S_IDLE && st_q != S_WAIT) || st_d == S_CU_SESS) &&
        is_k(LN_RX, rss_pkg::RSS_K_START)) begin
      ln_d = mk(rss_pkg::RSS_K_MS, 1'b1);
    end
    if (!cu_d.vld && st_q != S_IDLE && st_q != S_WAIT &&
        st_q != S_CU_SESS && st_q != S_CU_HOLD &&
        is_k(CU_RX, rss_pkg::RSS_K_START)) begin
      cu_d = mk(rss_pkg::RSS_K_MS, 1'b1);
    end
    // A retrain anywhere tears the whole span down
    if (retrain) begin
      st_d = S_IDLE;
      ln_d = mk(rss_pkg::RSS_K_DEACT, 1'b0);
      cu_d = mk(rss_pkg::RSS_K_DEACT, 1'b0);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_q <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Margins learnt from the line side or own on a local start, capabilities from each side
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || retrain) begin
      tm_cur_q <= rss_pkg::TM_RST;
      tm_wc_q  <= rss_pkg::TM_RST;
      co_q     <= 1'b0;
      diag_q   <= 1'b0;
    end else if (st_q == S_IDLE && REGEN_START &&
                 st_d == S_FWD_CU) begin
      tm_cur_q <= OWN_TM_CUR;
      tm_wc_q  <= OWN_TM_WC;
    end else if (st_q == S_LN_SESS && is_k(LN_RX, rss_pkg::RSS_K_CAPS)) begin
      tm_cur_q <= LN_RX.tm_cur;
      tm_wc_q  <= LN_RX.tm_wc;
      co_q     <= 1'b1;
      diag_q   <= LN_RX.diag;
    end
  end

  // Received capabilities; replaced by each new report
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || retrain) begin
      dn_caps_q <= ~rss_pkg::CAPS_RST;
      up_caps_q <= ~rss_pkg::CAPS_RST;
    end else begin
      if (is_k(CU_RX, rss_pkg::RSS_K_CAPS)) begin
        dn_caps_q <= CU_RX.caps;
      end else if (st_q == S_WAIT && tmr_exp && diag_q) begin
        dn_caps_q <= OWN_CAPS;
      end
      if (is_k(LN_RX, rss_pkg::RSS_K_CAPS)) begin
        up_caps_q <= LN_RX.caps;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      LN_TX <= rss_pkg::MSG_RST;
      CU_TX <= rss_pkg::MSG_RST;
    end else begin
      LN_TX <= ln_d;
      CU_TX <= cu_d;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SPAN_UP      <= 1'b0;
      STARTUP_FAIL <= 1'b0;
      DEACT_ALL    <= 1'b0;
    end else begin
      SPAN_UP      <= st_d == S_UP;
      STARTUP_FAIL <= st_q == S_WAIT && tmr_exp && !diag_q &&
                      st_d == S_IDLE;
      DEACT_ALL    <= retrain;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence ln_caps_in_s;
    st_q == S_LN_SESS && is_k(LN_RX, rss_pkg::RSS_K_CAPS) && !retrain;
  endsequence

  sequence cu_caps_out_s;
    CU_TX.vld && CU_TX.kind == rss_pkg::RSS_K_CAPS;
  endsequence

  ln_hold_rsp_a: assert property (ln_caps_in_s |=>
    LN_TX.vld && LN_TX.kind == rss_pkg::RSS_K_MS && LN_TX.rsp)
    else $error("line unit not held off");

  fwd_margin_a: assert property (ln_caps_in_s ##1 !retrain [*2]
    |=> cu_caps_out_s and (CU_TX.co_tm &&
        CU_TX.tm_cur == $past(LN_RX.tm_cur, 3) &&
        CU_TX.tm_wc == $past(LN_RX.tm_wc, 3)))
    else $error("forwarded margins wrong");

  caps_isect_a: assert property (LN_TX.vld &&
    LN_TX.kind == rss_pkg::RSS_K_CAPS |-> LN_TX.caps == (OWN_CAPS &
    $past(dn_caps_q)))
    else $error("advertised caps not intersected");

  glare_a: assert property ((st_q == S_IDLE || st_q == S_WAIT) &&
    is_k(CU_RX, rss_pkg::RSS_K_START) && !retrain |=> st_q == S_CU_SESS)
    else $error("collision priority wrong");

  retrain_all_a: assert property (retrain |=> DEACT_ALL &&
    LN_TX.kind == rss_pkg::RSS_K_DEACT && CU_TX.kind == rss_pkg::RSS_K_DEACT
    && st_q == S_IDLE)
    else $error("retrain did not clear span");

  fail_cause_a: assert property ($rose(STARTUP_FAIL) |->
    $past(tmr_exp) && !$past(diag_q) && st_q == S_IDLE)
    else $error("failure without timer expiry");

  diag_finish_a: assert property (st_q == S_WAIT && tmr_exp && diag_q &&
    !retrain && !CU_RX.vld && !LN_RX.vld |=> st_q == S_FWD_LN ##1
    LN_TX.kind == rss_pkg::RSS_K_START)
    else $error("diagnostic mode did not proceed");

  timer_arm_a: assert property (tmr_start && !retrain |=>
    tmr_run [*3])
    else $error("hold-off timer not armed");

  regen_start_a: assert property (st_q == S_IDLE && REGEN_START &&
    !LN_RX.vld && !CU_RX.vld |=> ##1 CU_TX.vld &&
    CU_TX.kind == rss_pkg::RSS_K_START)
    else $error("regenerator start not sent downstream");

  act_order_a: assert property (st_q == S_LN_ACT &&
    is_k(LN_RX, rss_pkg::RSS_K_ACT) && !retrain |=> ##1
    CU_TX.kind == rss_pkg::RSS_K_START ##1 CU_TX.kind == rss_pkg::RSS_K_MS)
    else $error("customer activation out of order");

endmodule : rss_regen_seq
`default_nettype wire
